// ---- irr_top.sv ----
// irr_top.sv: ir remote receiver with register port, flags and paddle fifo
// assumes ir_rx_n is an asynchronous pin, low while carrier is seen
`timescale 1ns/100ps
`include "irr_map.svh"
module irr_top
#(
  parameter int FIFO_DEPTH = 8
)
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ir_rx_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  output logic irq
);
  localparam int AW = $clog2(FIFO_DEPTH);

  if (FIFO_DEPTH < 2 || (1 << AW) != FIFO_DEPTH)
  begin : g_bad_depth
    $error("FIFO_DEPTH must be a power of two of at least 2");
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser and 10 us tick

  logic sync1_q;
  logic sync2_q;
  logic mark;
  logic [6:0] div_q;
  logic tick;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end
    else
    begin
      sync1_q <= ir_rx_n;
      sync2_q <= sync1_q;
    end
  end

  assign mark = ~sync2_q;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      div_q <= 7'h00;
    else if (div_q == 7'(`IRR_TICK_CYC - 1))
      div_q <= 7'h00;
    else
      div_q <= div_q + 7'h01;
  end

  assign tick = div_q == 7'(`IRR_TICK_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // control register and decoders

  logic pme_q;
  logic rxe_q;
  logic irqe_q;
  irr_pkg::irr_fmt_t fmt_q;
  logic [15:0] cc_q;
  logic wr_ctl;
  logic wr_stat;
  logic wr_cc;
  logic use_pd;

  assign wr_ctl = reg_we && reg_addr == `IRR_OFF_CTL;
  assign wr_stat = reg_we && reg_addr == `IRR_OFF_STAT;
  assign wr_cc = reg_we && reg_addr == `IRR_OFF_CC;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pme_q <= 1'b0;
      rxe_q <= 1'b0;
      irqe_q <= 1'b0;
      fmt_q <= irr_pkg::IRR_FMT_PD16;
    end
    else if (wr_ctl)
    begin
      pme_q <= reg_wdata[`IRR_CTL_PME];
      rxe_q <= reg_wdata[`IRR_CTL_RXE];
      irqe_q <= reg_wdata[`IRR_CTL_IRQE];
      fmt_q <= irr_pkg::irr_fmt_t'(reg_wdata[1:0]);
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      cc_q <= 16'h0000;
    else if (wr_cc)
      cc_q <= reg_wdata[15:0];
  end

  // paddle overrides the format field
  assign use_pd = pme_q | ~fmt_q[1];

  irr_evt_if pd_ev ();
  irr_evt_if bi_ev ();

  irr_pd_dec u_pd
  (
    .clock(clock),
    .arst_n(arst_n),
    .en(rxe_q & use_pd),
    .paddle(pme_q),
    .tick(tick),
    .lvl(mark),
    .ev(pd_ev)
  );

  irr_bi_dec u_bi
  (
    .clock(clock),
    .arst_n(arst_n),
    .en(rxe_q & ~use_pd),
    .rc6(fmt_q == irr_pkg::IRR_FMT_RC6),
    .tick(tick),
    .lvl(mark),
    .ev(bi_ev)
  );

  ////////////////////////////////////////////////////////////////////////////
  // event selection and code checks

  logic e_done;
  logic e_rpt;
  logic e_err;
  logic [15:0] e_user;
  logic [19:0] e_key;
  logic user_ok;
  logic key_ok;
  logic coded;
  logic frame_ok;
  logic frame_bad;

  assign e_done = use_pd ? pd_ev.done : bi_ev.done;
  assign e_rpt = use_pd ? pd_ev.rpt : bi_ev.rpt;
  assign e_err = use_pd ? pd_ev.err : bi_ev.err;
  assign e_user = use_pd ? pd_ev.user : bi_ev.user;
  assign e_key = use_pd ? pd_ev.key : bi_ev.key;
  assign coded = ~pme_q;

  always_comb
  begin
    unique case (fmt_q)
      irr_pkg::IRR_FMT_PD16,
      irr_pkg::IRR_FMT_PD8:
      begin
        user_ok = e_user == cc_q;
        key_ok = e_key[7:0] == ~e_key[15:8];
      end
      irr_pkg::IRR_FMT_RC5:
      begin
        user_ok = e_user[4:0] == cc_q[4:0];
        key_ok = 1'b1;
      end
      irr_pkg::IRR_FMT_RC6:
      begin
        user_ok = e_user[7:0] == cc_q[7:0];
        key_ok = 1'b1;
      end
    endcase
  end

  assign frame_ok = e_done & coded & user_ok & key_ok;
  assign frame_bad = coded & ((e_done & ~(user_ok & key_ok)) | e_err);

  ////////////////////////////////////////////////////////////////////////////
  // paddle fifo

  logic [19:0] mem_q [FIFO_DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic fifo_ne;
  logic push;
  logic pop;

  assign fifo_ne = cnt_q != '0;
  assign push = e_done & pme_q & (cnt_q != (AW+1)'(FIFO_DEPTH));
  assign pop = reg_re & (reg_addr == `IRR_OFF_KDC) & pme_q & fifo_ne;

  always_ff @(posedge clock)
  begin
    if (push)
      mem_q[wp_q] <= e_key;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wp_q <= wp_q + 1'b1;
      if (pop)
        rp_q <= rp_q + 1'b1;
      if (push && !pop)
        cnt_q <= cnt_q + 1'b1;
      else if (pop && !push)
        cnt_q <= cnt_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags: a hardware set wins over a software clear

  logic user_code_mismatch_pending_q;
  logic key_code_mismatch_pending_q;
  logic rcd_q;
  logic iip_q;
  logic receive_error_pending_q;
  logic last_bad_q;
  logic [7:0] w1c;

  assign w1c = wr_stat ? reg_wdata[7:0] : 8'h00;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      user_code_mismatch_pending_q <= 1'b0;
      key_code_mismatch_pending_q <= 1'b0;
      rcd_q <= 1'b0;
      receive_error_pending_q <= 1'b0;
    end
    else
    begin
      user_code_mismatch_pending_q <= (user_code_mismatch_pending_q & ~w1c[`IRR_ST_USER_CODE_MISMATCH_PENDING] & ~(e_done & coded & user_ok))
        | (e_done & coded & ~user_ok);
      key_code_mismatch_pending_q <= (key_code_mismatch_pending_q & ~w1c[`IRR_ST_KEY_CODE_MISMATCH_PENDING] & ~(e_done & coded & key_ok))
        | (e_done & coded & ~key_ok);
      rcd_q <= (rcd_q & ~w1c[`IRR_ST_RCD]) | (e_rpt & coded);
      receive_error_pending_q <= (receive_error_pending_q & ~w1c[`IRR_ST_RECEIVE_ERROR_PENDING] & ~frame_ok) | e_err;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      last_bad_q <= 1'b0;
    else if (frame_bad)
      last_bad_q <= 1'b1;
    else if (frame_ok)
      last_bad_q <= 1'b0;
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      iip_q <= 1'b0;
    else
      iip_q <= (iip_q & ~w1c[`IRR_ST_IIP]) | frame_ok
        | (e_rpt & coded & ~last_bad_q)
        | (pme_q & (fifo_ne | push));
  end

  assign irq = iip_q & irqe_q;

  ////////////////////////////////////////////////////////////////////////////
  // received code registers

  logic [19:0] key_q;
  logic [15:0] rcc_q;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      key_q <= 20'h00000;
      rcc_q <= 16'h0000;
    end
    else if (e_done && coded)
    begin
      key_q <= e_key;
      rcc_q <= e_user;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port, data one cycle after the strobe

  logic [31:0] rd_d;
  logic [31:0] rd_q;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    unique case (reg_addr)
      `IRR_OFF_CTL:
        rd_d = {27'h0, pme_q, rxe_q, irqe_q, fmt_q};
      `IRR_OFF_STAT:
      begin
        rd_d[`IRR_ST_FNE] = pme_q & fifo_ne;
        rd_d[`IRR_ST_USER_CODE_MISMATCH_PENDING] = user_code_mismatch_pending_q;
        rd_d[`IRR_ST_KEY_CODE_MISMATCH_PENDING] = key_code_mismatch_pending_q;
        rd_d[`IRR_ST_RCD] = rcd_q;
        rd_d[`IRR_ST_IIP] = iip_q;
        rd_d[`IRR_ST_RECEIVE_ERROR_PENDING] = receive_error_pending_q;
      end
      `IRR_OFF_CC:
        rd_d = {16'h0000, cc_q};
      `IRR_OFF_KDC:
        if (pme_q)
          rd_d = fifo_ne ? {12'h000, mem_q[rp_q]} : 32'h0000_0000;
        else
          rd_d = {12'h000, key_q};
      `IRR_OFF_RCC:
        rd_d = {16'h0000, rcc_q};
      default:
        rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rd_q <= 32'h0000_0000;
    else if (reg_re)
      rd_q <= rd_d;
    else
      rd_q <= 32'h0000_0000;
  end

  assign reg_rdata = rd_q;
endmodule // irr_top

// ---- irr_map.svh ----
// irr_map.svh: register map, field positions and timing counts of the ir receiver
// assumes a 10 MHz clock and a demodulated receiver pin that is low during a mark
// Operation
// - paddle mode overrides the coding format field, only paddle frames decode
// - format field: 00 16-bit pulse distance, 01 8-bit, 10 rc5, 11 rc6
// - status bit 7 shows paddle fifo not empty, only in paddle mode
// - user code mismatch sets bit 6, write 1 clears it
// - user code mismatch also clears on next frame with correct user code
// - key code mismatch sets bit 5, cleared by write 1 or next correct key
// - repeat code sets bit 4, held until software writes 1
// - interrupt pending bit 2 set on interrupt condition, write 1 clears
// - coded formats interrupt only when user code and key both correct
// - repeats following a bad frame raise no interrupt
// - paddle mode interrupt pending while paddle fifo not empty
// - pulses breaking the selected protocol set receive error bit 0
// - receive error clears on write 1 or a later fully correct frame
// - key register loads on a key value, unchanged by a repeat code
// - pulse distance key register: key in 7:0, inverted key in 15:8
`ifndef IRR_MAP_SVH
`define IRR_MAP_SVH
`define IRR_OFF_CTL 8'h00
`define IRR_OFF_STAT 8'h04
`define IRR_OFF_CC 8'h08
`define IRR_OFF_KDC 8'h0c
`define IRR_OFF_RCC 8'h14
`define IRR_CTL_PME 4
`define IRR_CTL_RXE 3
`define IRR_CTL_IRQE 2
`define IRR_ST_FNE 7
`define IRR_ST_USER_CODE_MISMATCH_PENDING 6
`define IRR_ST_KEY_CODE_MISMATCH_PENDING 5
`define IRR_ST_RCD 4
`define IRR_ST_IIP 2
`define IRR_ST_RECEIVE_ERROR_PENDING 0
`define IRR_CLK_MHZ 10
`define IRR_TICK_US 10
`define IRR_TICK_CYC (`IRR_TICK_US * `IRR_CLK_MHZ)
`define IRR_UP(us) (((us) + `IRR_TICK_US - 1) / `IRR_TICK_US)
`define IRR_DN(us) ((us) / `IRR_TICK_US)
`define IRR_LEAD_MIN `IRR_UP(4000)
`define IRR_DATA_SP_MIN `IRR_UP(3500)
`define IRR_RPT_SP_MIN `IRR_UP(1700)
`define IRR_RPT_SP_MAX `IRR_DN(2800)
`define IRR_ONE_SP_MIN `IRR_UP(1100)
`define IRR_BIT_SP_MIN `IRR_UP(300)
`define IRR_BIT_SP_MAX `IRR_DN(2500)
`define IRR_RUN_MAX `IRR_DN(10000)
`define IRR_PAD_LEAD `IRR_UP(150)
`define IRR_PAD_ONE `IRR_UP(105)
`define IRR_PAD_BITS 20
`define IRR_PD_BITS 32
`define IRR_RC5_UNIT `IRR_DN(889)
`define IRR_RC6_UNIT `IRR_DN(444)
`define IRR_RC5_HALVES 28
`define IRR_RC6_HALVES 52
`endif

// ---- irr_pkg.sv ----
// irr_pkg.sv: types shared by the ir receiver modules
// assumes nothing beyond the map header
package irr_pkg;
  typedef enum logic [1:0] {IRR_FMT_PD16 = 2'b00, IRR_FMT_PD8 = 2'b01,
    IRR_FMT_RC5 = 2'b10, IRR_FMT_RC6 = 2'b11} irr_fmt_t;
  typedef enum logic [2:0] {IRR_PD_IDLE = 3'b000, IRR_PD_LEAD = 3'b001,
    IRR_PD_LSP = 3'b010, IRR_PD_BMARK = 3'b011, IRR_PD_BSPACE = 3'b100} irr_pd_st_t;
endpackage

// ---- irr_evt_if.sv ----
// irr_evt_if.sv: frame events from a decoder to the register core
// assumes pulses last one clock and data are valid with them
`timescale 1ns/100ps
interface irr_evt_if;
  logic done;
  logic rpt;
  logic err;
  logic [15:0] user;
  logic [19:0] key;
  modport src (output done, rpt, err, user, key);
  modport dst (input done, rpt, err, user, key);
endinterface

// ---- irr_pd_dec.sv ----
// irr_pd_dec.sv: pulse-distance and paddle frame decoder
// assumes lvl synchronised and high during a mark, tick every 10 us
`timescale 1ns/100ps
`include "irr_map.svh"
module irr_pd_dec
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic en,
  input wire logic paddle,
  input wire logic tick,
  input wire logic lvl,
  irr_evt_if.src ev
);
  irr_pkg::irr_pd_st_t st_q;
  irr_pkg::irr_pd_st_t st_d;
  logic lvl_q;
  logic [10:0] run_q;
  logic [31:0] sh_q;
  logic [5:0] nb_q;
  logic done_q;
  logic rpt_q;
  logic err_q;
  logic rise;
  logic fall;
  logic take;
  logic bitv;
  logic fin;
  logic rpt;
  logic err;
  assign rise = lvl & ~lvl_q;
  assign fall = ~lvl & lvl_q;

  always_comb
  begin
    st_d = st_q;
    take = 1'b0;
    bitv = 1'b0;
    fin = 1'b0;
    rpt = 1'b0;
    err = 1'b0;
    unique case (st_q)
      irr_pkg::IRR_PD_IDLE:
        if (rise)
          st_d = irr_pkg::IRR_PD_LEAD;
      irr_pkg::IRR_PD_LEAD:
        if (fall)
        begin
          if (run_q < (paddle ? 11'(`IRR_PAD_LEAD) : 11'(`IRR_LEAD_MIN)))
            st_d = irr_pkg::IRR_PD_IDLE;
          else
            st_d = paddle ? irr_pkg::IRR_PD_BSPACE : irr_pkg::IRR_PD_LSP;
        end
      irr_pkg::IRR_PD_LSP:
        if (rise)
        begin
          rpt = (run_q >= 11'(`IRR_RPT_SP_MIN)) && (run_q <= 11'(`IRR_RPT_SP_MAX));
          err = (run_q < 11'(`IRR_DATA_SP_MIN)) && !rpt;
          st_d = (rpt || err) ? irr_pkg::IRR_PD_IDLE : irr_pkg::IRR_PD_BMARK;
        end
      irr_pkg::IRR_PD_BMARK:
        if (fall)
        begin
          st_d = irr_pkg::IRR_PD_BSPACE;
          if (paddle)
          begin
            take = 1'b1;
            bitv = run_q >= 11'(`IRR_PAD_ONE);
            fin = nb_q == 6'(`IRR_PAD_BITS - 1);
            if (fin)
              st_d = irr_pkg::IRR_PD_IDLE;
          end
        end
      irr_pkg::IRR_PD_BSPACE:
        if (rise)
        begin
          st_d = irr_pkg::IRR_PD_BMARK;
          if (!paddle)
          begin
            err = (run_q < 11'(`IRR_BIT_SP_MIN)) || (run_q > 11'(`IRR_BIT_SP_MAX));
            take = !err;
            bitv = run_q >= 11'(`IRR_ONE_SP_MIN);
            fin = nb_q == 6'(`IRR_PD_BITS - 1);
            if (fin || err)
              st_d = irr_pkg::IRR_PD_IDLE;
          end
        end
    endcase
    if (st_q != irr_pkg::IRR_PD_IDLE && st_q != irr_pkg::IRR_PD_LEAD && st_d == st_q
        && run_q == 11'(`IRR_RUN_MAX))
    begin
      err = 1'b1;
      st_d = irr_pkg::IRR_PD_IDLE;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_q <= irr_pkg::IRR_PD_IDLE;
      lvl_q <= 1'b0;
      run_q <= 11'h000;
    end
    else
    begin
      st_q <= en ? st_d : irr_pkg::IRR_PD_IDLE;
      lvl_q <= lvl;
      if (rise || fall)
        run_q <= 11'h000;
      else if (tick && run_q != 11'(`IRR_RUN_MAX))
        run_q <= run_q + 11'h001;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sh_q <= 32'h0000_0000;
      nb_q <= 6'h00;
    end
    else if (st_q == irr_pkg::IRR_PD_IDLE)
      nb_q <= 6'h00;
    else if (take)
    begin
      sh_q <= {bitv, sh_q[31:1]};
      nb_q <= nb_q + 6'h01;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      done_q <= 1'b0;
      rpt_q <= 1'b0;
      err_q <= 1'b0;
    end
    else
    begin
      done_q <= en & fin & ~err;
      rpt_q <= en & rpt & ~paddle;
      err_q <= en & err;
    end
  end

  assign ev.done = done_q;
  assign ev.rpt = rpt_q;
  assign ev.err = err_q;
  assign ev.user = sh_q[15:0];
  assign ev.key = paddle ? sh_q[31:12] : {4'h0, sh_q[31:16]};
endmodule // irr_pd_dec

// ---- irr_bi_dec.sv ----
// irr_bi_dec.sv: rc5 and rc6 bi-phase frame decoder
// assumes lvl synchronised and high during a mark, tick every 10 us
`timescale 1ns/100ps
`include "irr_map.svh"
module irr_bi_dec
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic en,
  input wire logic rc6,
  input wire logic tick,
  input wire logic lvl,
  irr_evt_if.src ev
);
  logic lvl_q;
  logic act_q;
  logic [6:0] sub_q;
  logic [51:0] hb_q;
  logic [5:0] hc_q;
  logic tog_q;
  logic pvld_q;
  logic [15:0] pcode_q;
  logic done_q;
  logic rpt_q;
  logic err_q;
  logic [7:0] user_q;
  logic [7:0] key_q;
  logic [6:0] unit;
  logic full;
  logic [25:0] bad;
  logic [25:0] v6;
  logic [25:0] v5;
  logic [7:0] u;
  logic [7:0] k;
  logic tg;
  logic er;
  logic same;
  assign unit = rc6 ? 7'(`IRR_RC6_UNIT) : 7'(`IRR_RC5_UNIT);
  assign full = act_q && hc_q == (rc6 ? 6'(`IRR_RC6_HALVES) : 6'(`IRR_RC5_HALVES));
  assign same = pvld_q && tg == tog_q && {u, k} == pcode_q;

  // half-bit pairs: rc6 bit is the first half, rc5 bit the second
  for (genvar p = 0; p < 26; p++)
  begin : g_pair
    assign bad[p] = hb_q[2*p] == hb_q[2*p+1];
    assign v6[p] = hb_q[2*p];
    assign v5[p] = hb_q[2*p+1];
  end

  always_comb
  begin
    u = 8'h00;
    k = 8'h00;
    if (rc6)
    begin
      for (int i = 0; i < 8; i++)
      begin
        u[7-i] = v6[10+i];
        k[7-i] = v6[18+i];
      end
      tg = hb_q[16];
      er = (|bad[25:10]) | (|bad[7:4]) | (hb_q[5:0] != 6'h3f) | (|hb_q[7:6]) | ~v6[4]
        | ~bad[8] | ~bad[9] | (hb_q[17] == hb_q[18]);
    end
    else
    begin
      for (int i = 0; i < 5; i++)
        u[4-i] = v5[3+i];
      for (int i = 0; i < 6; i++)
        k[5-i] = v5[8+i];
      tg = v5[2];
      er = (|bad[13:0]) | ~v5[0];
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lvl_q <= 1'b0;
      act_q <= 1'b0;
      sub_q <= 7'h00;
      hb_q <= 52'h0;
      hc_q <= 6'h00;
    end
    else
    begin
      lvl_q <= lvl;
      if (!en)
        act_q <= 1'b0;
      else if (!act_q)
      begin
        act_q <= lvl & ~lvl_q;
        sub_q <= 7'h00;
        hb_q[0] <= 1'b0;
        hc_q <= rc6 ? 6'h00 : 6'h01;
      end
      else if (full)
        act_q <= 1'b0;
      else if (lvl != lvl_q)
        sub_q <= 7'h00;
      else if (tick)
      begin
        sub_q <= (sub_q == unit - 7'h01) ? 7'h00 : sub_q + 7'h01;
        if (sub_q == (unit >> 1))
        begin
          hb_q[hc_q] <= lvl;
          hc_q <= hc_q + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      done_q <= 1'b0;
      rpt_q <= 1'b0;
      err_q <= 1'b0;
      user_q <= 8'h00;
      key_q <= 8'h00;
      tog_q <= 1'b0;
      pvld_q <= 1'b0;
      pcode_q <= 16'h0000;
    end
    else
    begin
      done_q <= full & ~er & ~same;
      rpt_q <= full & ~er & same;
      err_q <= full & er;
      if (full && !er)
      begin
        user_q <= u;
        key_q <= k;
        tog_q <= tg;
        pvld_q <= 1'b1;
        pcode_q <= {u, k};
      end
    end
  end

  assign ev.done = done_q;
  assign ev.rpt = rpt_q;
  assign ev.err = err_q;
  assign ev.user = {8'h00, user_q};
  assign ev.key = {12'h000, key_q};
endmodule // irr_bi_dec

// ---- irr_top_asserts.sv ----
// irr_top_asserts.sv: port-level checker for the ir receiver
// assumes it is bound into irr_top and sees only its ports
`timescale 1ns/100ps
module irr_top_asserts
#(
  parameter int FIFO_DEPTH = 8
)
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic ir_rx_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [31:0] reg_rdata,
  input wire logic irq
);
  logic [4:0] ctl_q;
  logic [3:0] calm_q;
  logic pin_q;
  logic quiet;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////
  // shadow of the control register
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      ctl_q <= 5'h00;
    else if (reg_we && reg_addr == 8'h00)
      ctl_q <= reg_wdata[4:0];
  end
  // cycles since the pin last moved; no edge-driven frame event can land while quiet, bi-phase events can
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pin_q <= 1'b1;
      calm_q <= 4'h0;
    end
    else
    begin
      pin_q <= ir_rx_n;
      calm_q <= (ir_rx_n != pin_q) ? 4'h0 : ((calm_q == 4'hf) ? calm_q : calm_q + 4'h1);
    end
  end
  assign quiet = (calm_q > 4'hb);
  ////////////////////////////////////////////////////////////////////////////
  AST_IRQ_MASK: assert property (!ctl_q[2] |-> !irq)
    else $error("irq high while irq enable clear");
  AST_IRQ_HOLD: assert property (irq && !reg_we |=> irq)
    else $error("irq fell without a register write");
  AST_IRQ_CLEAR: assert property (reg_we && reg_addr == 8'h04 && reg_wdata[2] && quiet && !ctl_q[4] |=> !irq)
    else $error("irq stayed after pending clear");
  AST_RISE_NEEDS_RX: assert property ($rose(irq) && !$past(reg_we) |-> $past(ctl_q[3]))
    else $error("irq rose with receiver disabled");
  AST_FNE_PADDLE: assert property ($past(reg_re) && $past(reg_addr) == 8'h04 && !ctl_q[4] |-> !reg_rdata[7])
    else $error("fifo flag set outside paddle mode");
  AST_PAD_PEND: assert property ($past(reg_re) && $past(reg_addr) == 8'h04 && reg_rdata[7] |-> reg_rdata[2])
    else $error("fifo not empty without irq pending");
  AST_CTL_READ: assert property ($past(reg_re) && $past(reg_addr) == 8'h00 |-> reg_rdata == {27'h0, ctl_q})
    else $error("control readback differs from last write");
  AST_FLAG_CLEAR: assert property ((reg_we && reg_addr == 8'h04 && quiet && !ctl_q[4]) ##2 (reg_re && reg_addr == 8'h04) |=> (reg_rdata & $past(reg_wdata, 3) & 32'h75) == 32'h0)
    else $error("status flag survived a write of one");
  cover property ($rose(irq));
  cover property ($past(reg_re) && $past(reg_addr) == 8'h04 && reg_rdata[7]);
  cover property (reg_we && reg_addr == 8'h04 && reg_wdata[2] && irq);
endmodule // irr_top_asserts
bind irr_top irr_top_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clock(clock), .arst_n(arst_n),
  .ir_rx_n(ir_rx_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq));

// ---- irr_ir_tx.sv ----
// irr_ir_tx.sv: behavioural remote transmitter on the demodulated pin
// assumes ns time units; pin idles high when no carrier is sent
`timescale 1ns/100ps
module irr_ir_tx
(
  output logic ir_rx_n
);
  initial ir_rx_n = 1'b1;
  // one mark then one space, in microseconds
  task mk(input int m, input int s);
    ir_rx_n = 1'b0;
    #(m * 1000);
    ir_rx_n = 1'b1;
    #(s * 1000);
  endtask
  // lead, n bits lsb first with long space for a one, closing mark
  task pd(input logic [31:0] w, input int sp, input int n);
    #20;
    mk(4200, sp);
    for (int i = 0; i < n; i++)
      mk(60, w[i] ? 1300 : 400);
    mk(60, 1000);
  endtask
  // short lead, then 20 marks, long mark for a one
  task pad(input logic [19:0] k);
    #20;
    mk(200, 100);
    for (int i = 0; i < 20; i++)
      mk(k[i] ? 130 : 50, 100);
    #1000000;
  endtask
  // 14 bi-phase bits msb first, a one is space then mark, 889 us halves
  task rc5(input logic [13:0] w);
    #20;
    for (int i = 13; i >= 0; i--)
    begin
      ir_rx_n = w[i];
      #889000;
      ir_rx_n = ~w[i];
      #889000;
    end
    ir_rx_n = 1'b1;
    #1000000;
  endtask
endmodule // irr_ir_tx

// ---- testbench.sv ----
// testbench.sv: self-checking bench for the ir receiver top
// assumes design, transmitter model and checker compiled before it
`timescale 1ns/100ps
module testbench;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic pend = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  wire ir_rx_n;
  int n_errors = 0;
  int checks = 0;
  logic [63:0] note_q[$];
  logic [63:0] nt;
  logic [15:0] usr;
  logic [7:0] k1;
  logic [7:0] k2;
  logic [19:0] kp;
  always #50 clock = ~clock;
  irr_top #(.FIFO_DEPTH(8)) uut (.clock(clock), .arst_n(arst_n), .ir_rx_n(ir_rx_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .irq(irq));
  irr_ir_tx tx (.ir_rx_n(ir_rx_n));
  ////////////////////////////////////////////////////////////////////////////
  task close_out;
    $display("mismatches %0d of %0d checks", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task bad(input logic [31:0] got, input logic [31:0] exp);
    n_errors++;
    $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clock);
    reg_we <= 1'b0;
    @(posedge clock);
  endtask
  // expectation noted first, monitor compares when data appear
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    note_q.push_back({m, e & m});
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clock);
    reg_re <= 1'b0;
    @(posedge clock);
  endtask
  task chk_irq(input logic v);
    checks++;
    if (irq !== v)
      bad({31'h0, irq}, {31'h0, v});
  endtask
  task frame(input logic [31:0] w, input int sp, input int n);
    tx.pd(w, sp, n);
    @(posedge clock);
    repeat (20) @(posedge clock);
  endtask
  always @(posedge clock)
  begin
    if (pend)
    begin
      nt = note_q.pop_front();
      checks++;
      if ((reg_rdata & nt[63:32]) !== nt[31:0])
        bad(reg_rdata & nt[63:32], nt[31:0]);
    end
    pend <= reg_re;
  end
  initial
  begin
    #600000000;
    n_errors++;
    close_out;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(95651));
    usr = 16'($urandom);
    k1 = 8'($urandom);
    k2 = 8'($urandom);
    kp = 20'($urandom);
    repeat (3) @(posedge clock);
    arst_n <= 1'b1;
    rd(8'h04, 32'h0, 32'hffffffff);
    rd(8'h40, 32'h0, 32'hffffffff);
    for (int f = 0; f < 4; f++)
    begin
      wr(8'h00, 32'h08 | f);
      rd(8'h00, 32'h08 | f, 32'hffffffff);
    end
    wr(8'h08, {16'h0, usr});
    wr(8'h00, 32'h04);
    frame({~k1, k1, usr}, 3700, 32);
    rd(8'h04, 32'h0, 32'h75);
    chk_irq(1'b0);
    wr(8'h00, 32'h0c);
    frame({~k1, k1, usr}, 3700, 32);
    chk_irq(1'b1);
    rd(8'h04, 32'h04, 32'h75);
    rd(8'h0c, {16'h0, ~k1, k1}, 32'hfffff);
    rd(8'h14, {16'h0, usr}, 32'hffff);
    wr(8'h04, 32'h04);
    chk_irq(1'b0);
    frame(32'h0, 2250, 0);
    rd(8'h04, 32'h14, 32'h75);
    rd(8'h0c, {16'h0, ~k1, k1}, 32'hfffff);
    wr(8'h04, 32'h14);
    rd(8'h04, 32'h0, 32'h75);
    frame({~k1, k1, ~usr}, 3700, 32);
    rd(8'h04, 32'h40, 32'h75);
    frame(32'h0, 2250, 0);
    rd(8'h04, 32'h50, 32'h75);
    chk_irq(1'b0);
    frame({k1, k1, usr}, 3700, 32);
    rd(8'h04, 32'h30, 32'h75);
    frame(32'h0, 3000, 0);
    rd(8'h04, 32'h31, 32'h75);
    frame({~k2, k2, usr}, 3700, 32);
    rd(8'h04, 32'h14, 32'h75);
    rd(8'h0c, {16'h0, ~k2, k2}, 32'hfffff);
    wr(8'h00, 32'h08);
    chk_irq(1'b0);
    wr(8'h04, 32'h75);
    wr(8'h00, 32'h0e);
    tx.rc5({3'b110, usr[4:0], k1[5:0]});
    repeat (20) @(posedge clock);
    chk_irq(1'b1);
    rd(8'h04, 32'h04, 32'h75);
    rd(8'h0c, {26'h0, k1[5:0]}, 32'hfffff);
    rd(8'h14, {27'h0, usr[4:0]}, 32'hffff);
    wr(8'h04, 32'h04);
    tx.rc5({3'b110, usr[4:0], k1[5:0]});
    repeat (20) @(posedge clock);
    rd(8'h04, 32'h14, 32'h75);
    wr(8'h04, 32'h14);
    wr(8'h00, 32'h1e);
    tx.pad(kp);
    @(posedge clock);
    repeat (20) @(posedge clock);
    chk_irq(1'b1);
    rd(8'h04, 32'h84, 32'hf5);
    rd(8'h0c, {12'h0, kp}, 32'hfffff);
    rd(8'h04, 32'h0, 32'h80);
    repeat (2) @(posedge clock);
    close_out;
  end
endmodule // testbench
